// [chg_mode_pkg.sv]
package chg_mode_pkg;

  // ****************************************
  // Clock and timing
  // ****************************************
  localparam int unsigned CLK_PERIOD_NS      = 10;
  localparam int unsigned ALERT_PULSE_NS     = 256;
  localparam int unsigned ALERT_PULSE_CYC    = (ALERT_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned BLINK_HALF_MS      = 500;
  localparam int unsigned BLINK_HALF_CYC_DEF = BLINK_HALF_MS * 100000;

  // ****************************************
  // Field encodings and reset values
  // ****************************************
  localparam logic [2:0] SRC_BOOST        = 3'h7;
  localparam logic [2:0] SRC_NONE         = 3'h0;
  localparam logic [1:0] BOOST_V_DEFAULT  = 2'h2;
  localparam logic [1:0] PHASE_DISABLED   = 2'h0;
  localparam logic [1:0] PHASE_PRECHARGE  = 2'h1;
  localparam logic [1:0] PHASE_FAST       = 2'h2;
  localparam logic [1:0] PHASE_DONE       = 2'h3;
  localparam logic [6:0] ICHG_DEFAULT     = 7'h22;
  localparam logic [3:0] IPRE_DEFAULT     = 4'h2;
  localparam logic [3:0] ITERM_DEFAULT    = 4'h3;
  localparam logic [6:0] VREG_DEFAULT     = 7'h2A;
  localparam logic       TIMER_10H        = 1'b0;
  localparam logic       PROFILE_ZONES    = 1'b1;

  // ****************************************
  // Types
  // ****************************************
  typedef enum logic [1:0] {
    MODE_IDLE   = 2'b00,
    MODE_CHARGE = 2'b01,
    MODE_BOOST  = 2'b10
  } mode_t;

  typedef enum logic [1:0] {
    CYC_OFF  = 2'b00,
    CYC_PRE  = 2'b01,
    CYC_FAST = 2'b10,
    CYC_DONE = 2'b11
  } cycle_t;

  typedef struct packed {
    logic       battery_switch_disable;
    logic       charge_enable_bit;
    logic       boost_enable_bit;
    logic       light_load_skip_disable;
    logic       thermistor_ignore_bit;
    logic       recharge_threshold_select;
    logic       boost_min_batt_select;
    logic [1:0] boost_voltage_select;
    logic [6:0] charge_current_setting;
  } cfg_t;

  typedef struct packed {
    logic adapter_present;
    logic converter_started;
    logic batt_above_boost_min_lo;
    logic batt_above_boost_min_hi;
    logic vin_below_batt_sleep;
    logic therm_in_boost_window;
    logic therm_fault;
    logic timer_fault;
    logic batt_below_precharge;
    logic ichg_below_term;
    logic batt_above_recharge_lo;
    logic batt_above_recharge_hi;
    logic iin_over_limit;
    logic vin_under_limit;
    logic thermal_reg;
    logic sys_at_min;
    logic sys_below_batt;
    logic batt_depleted;
  } sense_t;

  typedef struct packed {
    logic [6:0] vreg;
    logic [6:0] ichg;
    logic [3:0] ipre;
    logic [3:0] iterm;
    logic       profile;
    logic       timer_sel;
  } defaults_t;

endpackage

// [pulse_stretch.sv]
`timescale 1ns/1ps
module pulse_stretch
  import chg_mode_pkg::*;
(
  input  wire logic clk_i,
  input  wire logic rst_n_i,
  input  wire logic trig_i,
  output logic      pulse_n_o
);

  localparam logic [7:0] LEN = 8'(ALERT_PULSE_CYC);

  logic [7:0] count;

  // One fixed low pulse per trigger; a trigger during a pulse or its high gap
  // is dropped, not held, so consecutive events stay distinct
  logic gap;

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      count <= 8'h00;
      gap   <= 1'b0;
    end else if (count != 8'h00) begin
      count <= count - 8'h01;
      gap   <= (count == 8'h01);
    end else if (trig_i && !gap) begin
      count <= LEN;
      gap   <= 1'b0;
    end else begin
      gap <= 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      pulse_n_o <= 1'b1;
    end else begin
      pulse_n_o <= !((count > 8'h01) || (count == 8'h00 && trig_i && !gap));
    end
  end

endmodule

// [charger_mode_controller.sv]
`timescale 1ns/1ps
module charger_mode_controller
  import chg_mode_pkg::*;
#(
  parameter int unsigned BLINK_HALF_CYC = BLINK_HALF_CYC_DEF
) (
  input  wire logic                    MCLK_I,
  input  wire logic                    RESETN_I,
  input  wire chg_mode_pkg::cfg_t      CFG_I,
  input  wire chg_mode_pkg::sense_t    SENSE_I,
  input  wire logic                    CHARGE_EN_N_I,
  output chg_mode_pkg::mode_t          MODE_O,
  output logic [2:0]                   INPUT_SOURCE_STATUS_O,
  output logic                         PULSE_SKIP_EN_O,
  output logic                         INPUT_BLOCKING_SWITCH_O,
  output logic [1:0]                   BOOST_VOLTAGE_SELECT_O,
  output logic                         MIN_SYSTEM_REG_FLAG_O,
  output logic                         INPUT_VOLTAGE_LIMIT_FLAG_O,
  output logic                         INPUT_CURRENT_LIMIT_FLAG_O,
  output logic                         CHARGE_REDUCE_O,
  output logic                         BATTERY_SWITCH_O,
  output logic [1:0]                   CHARGE_PHASE_FIELD_O,
  output logic                         STATUS_PIN_O,
  output logic                         ALERT_N_O,
  output chg_mode_pkg::defaults_t      DEFAULTS_O
);
  import chg_mode_pkg::*;

  // ****************************************
  // Qualifying conditions
  // ****************************************
  function automatic logic pick(input logic sel, input logic lo, input logic hi);
    return sel ? hi : lo;
  endfunction

  logic boost_ok;
  logic start_ok;
  logic charge_enabled;
  logic limiting;
  logic term_ok;
  logic below_recharge;

  assign charge_enabled = CFG_I.charge_enable_bit && !CHARGE_EN_N_I;
  assign limiting       = SENSE_I.iin_over_limit || SENSE_I.vin_under_limit;

  // Register-side enables plus the analogue preconditions
  assign boost_ok = !CFG_I.battery_switch_disable && CFG_I.boost_enable_bit
                 && !(charge_enabled && SENSE_I.adapter_present)
                 && pick(CFG_I.boost_min_batt_select,
                         SENSE_I.batt_above_boost_min_lo,
                         SENSE_I.batt_above_boost_min_hi)
                 && SENSE_I.vin_below_batt_sleep
                 && (SENSE_I.therm_in_boost_window || CFG_I.thermistor_ignore_bit);

  assign start_ok = SENSE_I.converter_started && charge_enabled
                 && (CFG_I.charge_current_setting != 7'h00)
                 && (!SENSE_I.therm_fault || CFG_I.thermistor_ignore_bit)
                 && !SENSE_I.timer_fault && !CFG_I.battery_switch_disable;

  assign term_ok = SENSE_I.ichg_below_term
                && pick(CFG_I.recharge_threshold_select,
                        SENSE_I.batt_above_recharge_lo,
                        SENSE_I.batt_above_recharge_hi)
                && !limiting && !SENSE_I.thermal_reg;

  assign below_recharge = !pick(CFG_I.recharge_threshold_select,
                                SENSE_I.batt_above_recharge_lo,
                                SENSE_I.batt_above_recharge_hi);

  // ****************************************
  // Operating mode
  // ****************************************
  mode_t mode;
  mode_t next_mode;

  // Charging wins when an adapter is present and charging is enabled; boost only without an adapter
  always_comb begin
    next_mode = MODE_IDLE;
    if (SENSE_I.adapter_present && charge_enabled) begin
      next_mode = MODE_CHARGE;
    end else if (!SENSE_I.adapter_present && boost_ok) begin
      next_mode = MODE_BOOST;
    end
  end

  always_ff @(posedge MCLK_I) begin
    if (!RESETN_I) begin
      mode <= MODE_IDLE;
    end else begin
      mode <= next_mode;
    end
  end

  // ****************************************
  // Charge cycle
  // ****************************************
  cycle_t cycle;
  cycle_t next_cycle;
  logic   en_q;
  logic   adapter_q;
  logic   restart;

  always_ff @(posedge MCLK_I) begin
    if (!RESETN_I) begin
      en_q      <= 1'b0;
      adapter_q <= 1'b0;
    end else begin
      en_q      <= charge_enabled;
      adapter_q <= SENSE_I.adapter_present;
    end
  end

  // Toggling enable or replugging passes through OFF, so a rise restarts
  assign restart = (charge_enabled && !en_q)
                || (SENSE_I.adapter_present && !adapter_q);

  always_comb begin
    next_cycle = cycle;
    case (cycle)
      CYC_OFF: begin
        if (mode == MODE_CHARGE && start_ok) begin
          next_cycle = SENSE_I.batt_below_precharge ? CYC_PRE : CYC_FAST;
        end
      end
      CYC_PRE: begin
        if (!SENSE_I.batt_below_precharge) begin
          next_cycle = CYC_FAST;
        end
      end
      CYC_FAST: begin
        if (term_ok) begin
          next_cycle = CYC_DONE;
        end
      end
      CYC_DONE: begin
        if ((below_recharge || restart) && start_ok && mode == MODE_CHARGE) begin
          next_cycle = SENSE_I.batt_below_precharge ? CYC_PRE : CYC_FAST;
        end
      end
      default: next_cycle = CYC_OFF;
    endcase
    if (cycle != CYC_DONE && (mode != MODE_CHARGE || !start_ok)) begin
      next_cycle = CYC_OFF;
    end
    if (cycle == CYC_DONE && (!charge_enabled || !SENSE_I.adapter_present)) begin
      next_cycle = CYC_OFF;
    end
  end

  always_ff @(posedge MCLK_I) begin
    if (!RESETN_I) begin
      cycle <= CYC_OFF;
    end else begin
      cycle <= next_cycle;
    end
  end

  logic done_evt;
  assign done_evt = (cycle == CYC_FAST) && (next_cycle == CYC_DONE);

  // ****************************************
  // Status outputs
  // ****************************************
  always_ff @(posedge MCLK_I) begin
    if (!RESETN_I) begin
      INPUT_SOURCE_STATUS_O   <= SRC_NONE;
      PULSE_SKIP_EN_O         <= 1'b0;
      INPUT_BLOCKING_SWITCH_O <= 1'b0;
      BOOST_VOLTAGE_SELECT_O  <= BOOST_V_DEFAULT;
      MODE_O                  <= MODE_IDLE;
    end else begin
      MODE_O                  <= next_mode;
      INPUT_SOURCE_STATUS_O   <= (next_mode == MODE_BOOST) ? SRC_BOOST : SRC_NONE;
      PULSE_SKIP_EN_O         <= (next_mode == MODE_BOOST)
                                 && !CFG_I.light_load_skip_disable;
      INPUT_BLOCKING_SWITCH_O <= (next_mode != MODE_BOOST) && SENSE_I.adapter_present;
      BOOST_VOLTAGE_SELECT_O  <= CFG_I.boost_voltage_select;
    end
  end

  always_ff @(posedge MCLK_I) begin
    if (!RESETN_I) begin
      MIN_SYSTEM_REG_FLAG_O      <= 1'b0;
      INPUT_VOLTAGE_LIMIT_FLAG_O <= 1'b0;
      INPUT_CURRENT_LIMIT_FLAG_O <= 1'b0;
      CHARGE_REDUCE_O            <= 1'b0;
    end else begin
      MIN_SYSTEM_REG_FLAG_O      <= SENSE_I.sys_at_min;
      INPUT_VOLTAGE_LIMIT_FLAG_O <= SENSE_I.vin_under_limit;
      INPUT_CURRENT_LIMIT_FLAG_O <= SENSE_I.iin_over_limit;
      CHARGE_REDUCE_O            <= limiting;
    end
  end

  // Hysteresis lives in the two comparators: on below battery, off at depletion
  always_ff @(posedge MCLK_I) begin
    if (!RESETN_I) begin
      BATTERY_SWITCH_O <= 1'b0;
    end else if (SENSE_I.batt_depleted || CFG_I.battery_switch_disable) begin
      BATTERY_SWITCH_O <= 1'b0;
    end else if (SENSE_I.sys_below_batt) begin
      BATTERY_SWITCH_O <= 1'b1;
    end
  end

  always_ff @(posedge MCLK_I) begin
    if (!RESETN_I) begin
      CHARGE_PHASE_FIELD_O <= PHASE_DISABLED;
    end else begin
      case (next_cycle)
        CYC_PRE:  CHARGE_PHASE_FIELD_O <= PHASE_PRECHARGE;
        CYC_FAST: CHARGE_PHASE_FIELD_O <= PHASE_FAST;
        CYC_DONE: CHARGE_PHASE_FIELD_O <= PHASE_DONE;
        default:  CHARGE_PHASE_FIELD_O <= PHASE_DISABLED;
      endcase
    end
  end

  // ****************************************
  // Indicator pin
  // ****************************************
  // Wide counter so the 1 Hz blink needs no prescaler; shortened in simulation
  logic [31:0] blink_cnt;
  logic        blink;
  logic        fault;

  assign fault = SENSE_I.timer_fault
              || (SENSE_I.therm_fault && !CFG_I.thermistor_ignore_bit && charge_enabled);

  always_ff @(posedge MCLK_I) begin
    if (!RESETN_I || !fault) begin
      blink_cnt <= 32'h0000_0000;
      blink     <= 1'b0;
    end else if (blink_cnt >= BLINK_HALF_CYC - 1) begin
      blink_cnt <= 32'h0000_0000;
      blink     <= !blink;
    end else begin
      blink_cnt <= blink_cnt + 32'h0000_0001;
    end
  end

  always_ff @(posedge MCLK_I) begin
    if (!RESETN_I) begin
      STATUS_PIN_O <= 1'b1;
    end else if (fault) begin
      STATUS_PIN_O <= blink;
    end else begin
      STATUS_PIN_O <= !(next_cycle == CYC_PRE || next_cycle == CYC_FAST);
    end
  end

  // ****************************************
  // Host alert and defaults
  // ****************************************
  pulse_stretch u_alert (
    .clk_i     (MCLK_I),
    .rst_n_i   (RESETN_I),
    .trig_i    (done_evt),
    .pulse_n_o (ALERT_N_O)
  );

  always_ff @(posedge MCLK_I) begin
    if (!RESETN_I) begin
      DEFAULTS_O <= '{vreg: VREG_DEFAULT, ichg: ICHG_DEFAULT, ipre: IPRE_DEFAULT,
                      iterm: ITERM_DEFAULT, profile: PROFILE_ZONES,
                      timer_sel: TIMER_10H};
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  sequence done_seq;
    cycle == CYC_FAST ##1 cycle == CYC_DONE;
  endsequence

  boost_needs_enables_a: assert property (@(posedge MCLK_I) disable iff (!RESETN_I)
    mode == MODE_BOOST |-> $past(CFG_I.boost_enable_bit && !CFG_I.battery_switch_disable))
    else $error("boost active without enables");

  boost_source_code_a: assert property (@(posedge MCLK_I) disable iff (!RESETN_I)
    MODE_O == MODE_BOOST |-> INPUT_SOURCE_STATUS_O == 3'h7)
    else $error("source status not 111 in boost");

  boost_blocks_input_a: assert property (@(posedge MCLK_I) disable iff (!RESETN_I)
    MODE_O == MODE_BOOST |-> !INPUT_BLOCKING_SWITCH_O)
    else $error("blocking switch on in boost");

  skip_disable_a: assert property (@(posedge MCLK_I) disable iff (!RESETN_I)
    PULSE_SKIP_EN_O |-> MODE_O == MODE_BOOST && !$past(CFG_I.light_load_skip_disable))
    else $error("pulse skip while disabled");

  start_needs_ok_a: assert property (@(posedge MCLK_I) disable iff (!RESETN_I)
    cycle == CYC_OFF ##1 cycle != CYC_OFF |-> $past(start_ok))
    else $error("cycle started without conditions");

  term_needs_ok_a: assert property (@(posedge MCLK_I) disable iff (!RESETN_I)
    done_seq |-> $past(term_ok))
    else $error("termination without conditions");

  done_alert_a: assert property (@(posedge MCLK_I) disable iff (!RESETN_I)
    done_seq |-> ##1 !ALERT_N_O)
    else $error("no alert after completion");

  phase_done_a: assert property (@(posedge MCLK_I) disable iff (!RESETN_I)
    cycle == CYC_DONE |-> CHARGE_PHASE_FIELD_O == 2'h3)
    else $error("phase field not done");

  indicator_low_a: assert property (@(posedge MCLK_I) disable iff (!RESETN_I)
    (cycle == CYC_FAST && !fault) |-> !STATUS_PIN_O)
    else $error("indicator high while charging");

  alert_gap_a: assert property (@(posedge MCLK_I) disable iff (!RESETN_I)
    $rose(ALERT_N_O) |=> ALERT_N_O)
    else $error("alert pulses merged");

  batt_switch_off_a: assert property (@(posedge MCLK_I) disable iff (!RESETN_I)
    SENSE_I.batt_depleted |=> !BATTERY_SWITCH_O)
    else $error("battery switch on below depletion");

endmodule

// [chg_host_model.sv]
`timescale 1ns/1ps
module chg_host_model (
  input  wire logic          clk_i,
  output chg_mode_pkg::cfg_t cfg_o,
  output logic               ce_n_o
);
  import chg_mode_pkg::*;

  // ********************************
  // Configuration held by the host
  // ********************************
  // Boost target left at 5.0 V, so it clears a 4.6 V cell by 350 mV or more
  initial begin
    cfg_o                      = '0;
    cfg_o.boost_voltage_select = BOOST_V_DEFAULT;
    ce_n_o                     = 1'b1;
  end

  // Called at a rising edge; takes effect through non-blocking assignment
  task automatic put(input cfg_t c, input logic ce_n);
    cfg_o  <= c;
    ce_n_o <= ce_n;
  endtask

  // Restart after done: enable bit low for a few cycles, then high again
  task automatic toggle_enable();
    cfg_t c;
    c                   = cfg_o;
    c.charge_enable_bit = 1'b0;
    @(posedge clk_i);
    put(c, ce_n_o);
    repeat (4) @(posedge clk_i);
    c.charge_enable_bit = 1'b1;
    put(c, ce_n_o);
  endtask
endmodule

// [charger_mode_controller_bench.sv]
`timescale 1ns/1ps
`define CHK(g, e) check_eq(32'(g), 32'(e), `__LINE__)
module charger_mode_controller_bench;
  import chg_mode_pkg::*;

  localparam int unsigned BLINK = 4;
  localparam int unsigned LIMIT = 5000;

  logic       mclk = 1'b0;
  logic       resetn = 1'b0;
  sense_t     sn = '0;
  sense_t     s = '0;
  cfg_t       c = '0;
  logic       ce = 1'b1;
  cfg_t       cfg;
  logic       ce_n;
  mode_t      mode;
  logic [2:0] src;
  logic       skip;
  logic       blk;
  logic [1:0] bsel;
  logic       fmin;
  logic       fvlim;
  logic       filim;
  logic       reduce;
  logic       bsw;
  logic [1:0] phase;
  logic       stat;
  logic       alert_n;
  defaults_t  dflt;
  int         err_count = 0;
  int         tests_run = 0;
  int         cyc = 0;

  always #(CLK_PERIOD_NS / 2) mclk = ~mclk;

  chg_host_model u_host (
    .clk_i  (mclk),
    .cfg_o  (cfg),
    .ce_n_o (ce_n)
  );

  charger_mode_controller #(.BLINK_HALF_CYC(BLINK)) u_dut (
    .MCLK_I                     (mclk),
    .RESETN_I                   (resetn),
    .CFG_I                      (cfg),
    .SENSE_I                    (sn),
    .CHARGE_EN_N_I              (ce_n),
    .MODE_O                     (mode),
    .INPUT_SOURCE_STATUS_O      (src),
    .PULSE_SKIP_EN_O            (skip),
    .INPUT_BLOCKING_SWITCH_O    (blk),
    .BOOST_VOLTAGE_SELECT_O     (bsel),
    .MIN_SYSTEM_REG_FLAG_O      (fmin),
    .INPUT_VOLTAGE_LIMIT_FLAG_O (fvlim),
    .INPUT_CURRENT_LIMIT_FLAG_O (filim),
    .CHARGE_REDUCE_O            (reduce),
    .BATTERY_SWITCH_O           (bsw),
    .CHARGE_PHASE_FIELD_O       (phase),
    .STATUS_PIN_O               (stat),
    .ALERT_N_O                  (alert_n),
    .DEFAULTS_O                 (dflt)
  );

  // ********************************
  // Helpers
  // ********************************
  task automatic close_out();
    if (err_count == 0 && tests_run > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  task automatic check_eq(input logic [31:0] got, input logic [31:0] exp, input int ln);
    tests_run++;
    if (got !== exp) begin
      err_count++;
      $display("Error at %0t: line %0d got %0h expected %0h", $time, ln, got, exp);
    end
  endtask

  task automatic step(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask

  task automatic apply(input int n);
    @(posedge mclk);
    sn <= s;
    u_host.put(c, ce);
    step(n);
  endtask

  // Counts low cycles of the alert line over a window longer than one pulse
  task automatic alert_low(output int n);
    n = 0;
    repeat (40) begin
      step(1);
      if (alert_n === 1'b0)
        n++;
    end
  endtask

  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == LIMIT) begin
      err_count++;
      close_out();
    end
  end

  // ********************************
  // Tests
  // ********************************
  initial begin
    int     n;
    logic   b;
    sense_t sb;
    cfg_t   cb;
    repeat (10) @(posedge mclk);
    #1;
    `CHK(mode, MODE_IDLE);
    `CHK(phase, PHASE_DISABLED);
    `CHK(stat, 1'b1);
    `CHK(alert_n, 1'b1);
    `CHK(bsel, BOOST_V_DEFAULT);
    `CHK(dflt, {VREG_DEFAULT, ICHG_DEFAULT, IPRE_DEFAULT, ITERM_DEFAULT, PROFILE_ZONES, TIMER_10H});
    @(posedge mclk);
    resetn <= 1'b1;
    for (int i = 0; i < 6; i++) begin
      s                        = '0;
      s.adapter_present        = 1'b1;
      s.converter_started      = (i != 0);
      s.therm_fault            = (i == 1);
      s.timer_fault            = (i == 2);
      c                        = '0;
      c.charge_enable_bit      = 1'b1;
      c.charge_current_setting = (i == 3) ? 7'h00 : ICHG_DEFAULT;
      c.battery_switch_disable = (i == 4);
      ce                       = (i == 5);
      apply(3);
      `CHK(phase, PHASE_DISABLED);
    end
    s.therm_fault           = 1'b1;
    c.thermistor_ignore_bit = 1'b1;
    ce                      = 1'b0;
    apply(3);
    `CHK(phase, PHASE_FAST);
    ce = 1'b1;
    apply(3);
    `CHK(phase, PHASE_DISABLED);
    `CHK(stat, 1'b1);
    s.therm_fault           = 1'b0;
    c.thermistor_ignore_bit = 1'b0;
    s.batt_below_precharge  = 1'b1;
    ce                      = 1'b0;
    apply(3);
    `CHK(mode, MODE_CHARGE);
    `CHK(phase, PHASE_PRECHARGE);
    `CHK(stat, 1'b0);
    `CHK(blk, 1'b1);
    s.batt_below_precharge = 1'b0;
    apply(3);
    `CHK(phase, PHASE_FAST);
    s.ichg_below_term        = 1'b1;
    s.batt_above_recharge_lo = 1'b1;
    s.batt_above_recharge_hi = 1'b1;
    for (int i = 0; i < 3; i++) begin
      s.iin_over_limit  = (i == 0);
      s.vin_under_limit = (i == 1);
      s.thermal_reg     = (i == 2);
      apply(3);
      `CHK(phase, PHASE_FAST);
      `CHK(filim, i == 0);
      `CHK(fvlim, i == 1);
      `CHK(reduce, i < 2);
    end
    s.thermal_reg = 1'b0;
    apply(0);
    alert_low(n);
    `CHK(n, ALERT_PULSE_CYC);
    `CHK(phase, PHASE_DONE);
    `CHK(stat, 1'b1);
    // Only the selected comparator drops, so a select that is ignored shows up
    c.recharge_threshold_select = 1'b1;
    s.batt_above_recharge_hi    = 1'b0;
    apply(3);
    `CHK(phase, PHASE_FAST);
    s.batt_above_recharge_lo = 1'b1;
    s.batt_above_recharge_hi = 1'b1;
    apply(0);
    alert_low(n);
    `CHK(n, ALERT_PULSE_CYC);
    s.ichg_below_term = 1'b0;
    apply(3);
    `CHK(phase, PHASE_DONE);
    u_host.toggle_enable();
    step(3);
    `CHK(phase, PHASE_FAST);
    s.ichg_below_term = 1'b1;
    apply(0);
    alert_low(n);
    `CHK(n, ALERT_PULSE_CYC);
    s.ichg_below_term = 1'b0;
    s.adapter_present = 1'b0;
    apply(3);
    s.adapter_present = 1'b1;
    apply(3);
    `CHK(phase, PHASE_FAST);
    // A stuck-at indicator fails here as well as a wrong blink rate
    s.timer_fault = 1'b1;
    apply(2);
    n = 0;
    for (int i = 0; i < 20; i++) begin
      b = stat;
      step(1);
      if (stat !== b)
        n++;
    end
    `CHK((n >= 20 / BLINK - 2) && (n <= 20 / BLINK + 1), 1'b1);
    s.timer_fault    = 1'b0;
    s.sys_at_min     = 1'b1;
    s.sys_below_batt = 1'b1;
    apply(2);
    `CHK(fmin, 1'b1);
    `CHK(bsw, 1'b1);
    s.sys_at_min     = 1'b0;
    s.sys_below_batt = 1'b0;
    apply(2);
    `CHK(fmin, 1'b0);
    `CHK(bsw, 1'b1);
    s.batt_depleted = 1'b1;
    apply(2);
    `CHK(bsw, 1'b0);
    s                         = '0;
    s.batt_above_boost_min_lo = 1'b1;
    s.batt_above_boost_min_hi = 1'b1;
    s.vin_below_batt_sleep    = 1'b1;
    s.therm_in_boost_window   = 1'b1;
    c                         = '0;
    c.boost_enable_bit        = 1'b1;
    ce                        = 1'b1;
    for (int i = 0; i < 4; i++) begin
      c.boost_voltage_select    = 2'(i);
      c.light_load_skip_disable = i[0];
      apply(3);
      `CHK(mode, MODE_BOOST);
      `CHK(src, SRC_BOOST);
      `CHK(blk, 1'b0);
      `CHK(skip, !i[0]);
      `CHK(bsel, i);
    end
    sb = s;
    cb = c;
    for (int i = 0; i < 7; i++) begin
      s = sb;
      c = cb;
      ce = (i != 1);
      case (i)
        0: c.battery_switch_disable = 1'b1;
        1: begin
          c.charge_enable_bit = 1'b1;
          s.adapter_present   = 1'b1;
        end
        2: c.boost_enable_bit = 1'b0;
        3: begin
          s.batt_above_boost_min_lo = 1'b0;
          s.batt_above_boost_min_hi = 1'b0;
        end
        4: s.vin_below_batt_sleep = 1'b0;
        5: s.therm_in_boost_window = 1'b0;
        default: begin
          c.boost_min_batt_select   = 1'b1;
          s.batt_above_boost_min_hi = 1'b0;
        end
      endcase
      apply(3);
      `CHK(mode == MODE_BOOST, 1'b0);
      `CHK(src, SRC_NONE);
    end
    c                        = cb;
    c.charge_enable_bit      = 1'b1;
    c.charge_current_setting = ICHG_DEFAULT;
    ce                       = 1'b0;
    s                        = sb;
    s.adapter_present        = 1'b1;
    s.converter_started      = 1'b1;
    s.vin_below_batt_sleep   = 1'b0;
    apply(3);
    `CHK(mode, MODE_CHARGE);
    `CHK(blk, 1'b1);
    s.adapter_present      = 1'b0;
    s.vin_below_batt_sleep = 1'b1;
    apply(3);
    `CHK(mode, MODE_BOOST);
    `CHK(blk, 1'b0);
    close_out();
  end
endmodule
